// [cbuf_pkg.sv]
// Constants, state encodings and the state record of the clock buffer
// configuration bank. Assumes one system clock of 250 MHz.
package cbuf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Target address, upper four bits; the lower three come from the strap
  localparam logic [3:0] ADDR_HI = 4'hD;

  // Register indices
  localparam logic [7:0] REG_OUT_EN = 8'h00;
  localparam logic [7:0] REG_PLL_AMP = 8'h01;
  localparam logic [7:0] REG_SLEW = 8'h02;
  localparam logic [7:0] REG_FREQ = 8'h03;
  localparam logic [7:0] REG_RSVD = 8'h04;
  localparam logic [7:0] REG_REV_VEN = 8'h05;
  localparam logic [7:0] REG_DEV_TYPE = 8'h06;
  localparam logic [7:0] REG_RD_CNT = 8'h07;

  // Field positions (low bit of multi-bit fields)
  localparam int BIT_OUT1 = 5;
  localparam int BIT_OUT0 = 3;
  localparam int BIT_PLL_RB = 6;
  localparam int BIT_PLL_OVR = 5;
  localparam int BIT_PLL_SW = 3;
  localparam int BIT_AMP = 0;
  localparam int BIT_FSEL_EN = 5;
  localparam int BIT_FCODE = 3;
  localparam int BIT_FB_SLEW = 0;
  localparam int BIT_REV = 4;
  localparam int BIT_KIND = 6;

  // Reserved bits read back as ones, except in the byte count register
  localparam logic [7:0] RSV_FILL = 8'hFF;
  localparam logic [2:0] CNT_RSV = 3'h0;

  // Reset values
  localparam logic RST_OUT_EN = 1'h1;
  localparam logic RST_PLL_OVR = 1'h0;
  localparam logic [1:0] RST_PLL_SW = 2'h0;
  localparam logic [1:0] RST_AMP = 2'h2;
  localparam logic RST_SLEW = 1'h1;
  localparam logic RST_FSEL_EN = 1'h0;
  localparam logic [1:0] RST_FCODE = 2'h0;
  localparam logic RST_FB_SLEW = 1'h1;
  localparam logic [4:0] RST_RD_CNT = 5'h08;

  // PLL operating modes and frequency codes
  localparam logic [1:0] PLL_LOW_BW = 2'h0;
  localparam logic [1:0] PLL_BYPASS = 2'h1;
  localparam logic [1:0] PLL_HIGH_BW = 2'h3;
  localparam logic [1:0] FREQ_100 = 2'h0;
  localparam logic [1:0] FREQ_50 = 2'h1;
  localparam logic [1:0] FREQ_125 = 2'h2;

  // Identification; revision, vendor and part values are arbitrary
  localparam logic [3:0] REV_ID = 4'h6;
  localparam logic [3:0] VENDOR_ID = 4'h9;
  localparam logic [1:0] ZERO_DELAY_BUFFER_TYPE = 2'h1;
  localparam logic [5:0] PART_ID = 6'h2A;

  // Timing
  localparam int CLK_MHZ = 250;
  localparam int STAB_US = 600;
  localparam int STAB_CYC = STAB_US * CLK_MHZ;
  localparam logic [1:0] STRAP_WAIT = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    FSM_IDLE, FSM_ADDR, FSM_RX, FSM_ACK, FSM_TX, FSM_HACK, FSM_IGN
  } cbuf_fsm_e;

  typedef struct packed {
    cbuf_fsm_e state;
    logic [3:0] bitcnt;
    logic [7:0] sh;
    logic [1:0] stage;
    logic [7:0] idx;
    logic is_read;
    logic acked;
    logic sda_oe_b;
    logic sda_lvl;
    logic scl_d;
    logic sda_d;
    logic en1;
    logic en0;
    logic pll_ovr;
    logic [1:0] pll_sw;
    logic [1:0] amp;
    logic slew1;
    logic slew0;
    logic fsel_en;
    logic [1:0] fcode;
    logic fb_fast;
    logic [4:0] bcount;
    logic [1:0] bw_mode;
    logic [2:0] addr_lo;
    logic [1:0] strap_wait;
    logic strap_done;
    logic [17:0] stab_cnt;
    logic stab_done;
    logic o0p;
    logic o0n;
    logic o1p;
    logic o1n;
    logic [1:0] pll_mode;
    logic [1:0] freq;
  } cbuf_state_s;

  localparam cbuf_state_s ST_RST = '{
    state: FSM_IDLE, sda_oe_b: 1'h1, scl_d: 1'h1, sda_d: 1'h1,
    en1: RST_OUT_EN, en0: RST_OUT_EN, pll_ovr: RST_PLL_OVR,
    pll_sw: RST_PLL_SW, amp: RST_AMP, slew1: RST_SLEW, slew0: RST_SLEW,
    fsel_en: RST_FSEL_EN, fcode: RST_FCODE, fb_fast: RST_FB_SLEW,
    bcount: RST_RD_CNT, freq: FREQ_100, default: '0
  };

endpackage : cbuf_pkg

// [cbuf_sync.sv]
// Two-stage synchroniser for a group of asynchronous pin levels.
// Assumes the levels are quasi-static compared with the clock.
`timescale 1ns/10ps
`default_nettype none
module cbuf_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } cbuf_sync_s;

  cbuf_sync_s r;
  cbuf_sync_s n;

  // First stage only feeds the second; nothing else may look at it
  always_comb begin
    n = r;
    n.s1 = d_i;
    n.s2 = r.s1;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign q_o = r.s2;

endmodule : cbuf_sync
`default_nettype wire

// [cbuf_smbus_cfg.sv]
// Configuration bank of a two-output clock fanout buffer, reached by an
// SMBus target interface, plus output gating and start-up hold-off.
// Assumes SCL, SDA, enable pins and straps arrive asynchronously.
//
// Function
// RULE1: Target only, one 7-bit address plus R/W, block read/write only.
// RULE2: Stop after any complete byte ends a transfer cleanly.
// RULE3: Address is 1101 followed by the three latched strap bits.
// RULE4: Block write: index, count, data bytes; every byte acknowledged.
// RULE5: Block read: count then data from index; host NACK ends it.
// RULE6: Enable bits for outputs 1 and 0, reset 1; 0 forces low/low.
// RULE7: PLL mode readback bits show the latched bandwidth strap.
// RULE8: Override bit picks software mode bits over strapped mode.
// RULE9: Two amplitude bits, 0.6 V to 0.9 V, reset code 10.
// RULE10: Slew bits per output, 1 fast, 0 slow, reset 1.
// RULE11: Frequency select enable, reset 0; off means default frequency.
// RULE12: Frequency code bits, reset 00, used only when enabled.
// RULE13: Feedback slew bit, reset 1; 1 fast, 0 slow.
// RULE14: Revision and vendor identifiers, read only.
// RULE15: Device type and part identifier, read only.
// RULE16: Read byte count five bits, default 8, upper bits read 0.
// RULE17: First output clock within the start-up time after power-up.
// RULE18: Outputs run only with power up, bit set and pin low.
// RULE19: Mode codes: 00 low bandwidth, 01 bypass, 11 high bandwidth.
// RULE20: Frequency codes: 00 100 MHz, 01 50 MHz, 10 125 MHz.
// RULE21: Outputs start and stop within 1 to 3 output cycles.
// RULE22: Read-only writes ignored; index advances once per byte.
`timescale 1ns/10ps
`default_nettype none
module cbuf_smbus_cfg #(
  parameter int STAB_CYCLES = cbuf_pkg::STAB_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic out0_enable_pin_n_i,
  input wire logic out1_enable_pin_n_i,
  input wire logic power_down_pin_n_i,
  input wire logic [1:0] bandwidth_strap_pin_i,
  input wire logic [2:0] address_select_strap_i,
  output logic sda_o,
  output logic sda_oe_b_o,
  output logic out0_pair_p_o,
  output logic out0_pair_n_o,
  output logic out1_pair_p_o,
  output logic out1_pair_n_o,
  output logic [1:0] pll_mode_o,
  output logic [1:0] amplitude_o,
  output logic out0_slew_fast_o,
  output logic out1_slew_fast_o,
  output logic [1:0] freq_code_o,
  output logic feedback_slew_fast_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation
  logic [9:0] sy;
  logic scl_s;
  logic sda_s;
  logic oe0_s;
  logic oe1_s;
  logic pd_s;
  logic [1:0] bw_s;
  logic [2:0] address_select_strap_s;

  cbuf_sync #(
    .WIDTH(10)
  ) u_sync (
    .clk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .d_i({scl_i, sda_i, out0_enable_pin_n_i, out1_enable_pin_n_i,
          power_down_pin_n_i, bandwidth_strap_pin_i,
          address_select_strap_i}),
    .q_o(sy)
  );

  assign {scl_s, sda_s, oe0_s, oe1_s, pd_s, bw_s, address_select_strap_s} = sy;

  cbuf_pkg::cbuf_state_s r;
  cbuf_pkg::cbuf_state_s n;

  ////////////////////////////////////////////////////////////////////////////
  // Bus events on the synchronised lines; none until the straps are caught
  logic rise_w;
  logic fall_w;
  logic start_w;
  logic stop_w;
  logic run0_w;
  logic run1_w;
  logic addr_hit_w;

  assign rise_w = r.strap_done & scl_s & ~r.scl_d;
  assign fall_w = r.strap_done & ~scl_s & r.scl_d;
  assign start_w = r.strap_done & scl_s & r.scl_d & r.sda_d & ~sda_s;
  assign stop_w = r.strap_done & scl_s & r.scl_d & ~r.sda_d & sda_s;
  assign addr_hit_w = (r.sh[7:1] == {cbuf_pkg::ADDR_HI, r.addr_lo}); // [RULE3]
  assign run0_w = pd_s & r.en0 & ~oe0_s & r.stab_done; // [RULE18]
  assign run1_w = pd_s & r.en1 & ~oe1_s & r.stab_done; // [RULE18]

  ////////////////////////////////////////////////////////////////////////////
  // Register read view
  function automatic logic [7:0] rd_byte(input cbuf_pkg::cbuf_state_s s,
                                         input logic [7:0] idx);
    logic [7:0] b;
    b = cbuf_pkg::RSV_FILL;
    case (idx)
      cbuf_pkg::REG_OUT_EN: begin
        b[cbuf_pkg::BIT_OUT1] = s.en1;
        b[cbuf_pkg::BIT_OUT0] = s.en0;
      end
      cbuf_pkg::REG_PLL_AMP: begin
        b[cbuf_pkg::BIT_PLL_RB +: 2] = s.bw_mode; // [RULE7]
        b[cbuf_pkg::BIT_PLL_OVR] = s.pll_ovr;
        b[cbuf_pkg::BIT_PLL_SW +: 2] = s.pll_sw;
        b[cbuf_pkg::BIT_AMP +: 2] = s.amp;
      end
      cbuf_pkg::REG_SLEW: begin
        b[cbuf_pkg::BIT_OUT1] = s.slew1;
        b[cbuf_pkg::BIT_OUT0] = s.slew0;
      end
      cbuf_pkg::REG_FREQ: begin
        b[cbuf_pkg::BIT_FSEL_EN] = s.fsel_en;
        b[cbuf_pkg::BIT_FCODE +: 2] = s.fcode;
        b[cbuf_pkg::BIT_FB_SLEW] = s.fb_fast;
      end
      cbuf_pkg::REG_RSVD: begin
        b = cbuf_pkg::RSV_FILL;
      end
      cbuf_pkg::REG_REV_VEN: begin
        b = {cbuf_pkg::REV_ID, cbuf_pkg::VENDOR_ID}; // [RULE14]
      end
      cbuf_pkg::REG_DEV_TYPE: begin
        b = {cbuf_pkg::ZERO_DELAY_BUFFER_TYPE, cbuf_pkg::PART_ID}; // [RULE15]
      end
      cbuf_pkg::REG_RD_CNT: begin
        b = {cbuf_pkg::CNT_RSV, s.bcount}; // [RULE16]
      end
      default: begin
        b = 8'h00;
      end
    endcase
    return b;
  endfunction : rd_byte

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    logic [7:0] tb;
    tb = rd_byte(r, r.idx);
    n = r;
    n.scl_d = scl_s;
    n.sda_d = sda_s;

    // Straps are caught once, after the synchronisers have settled
    if (!r.strap_done) begin
      n.strap_wait = r.strap_wait + 2'h1;
      if (r.strap_wait == cbuf_pkg::STRAP_WAIT) begin
        n.bw_mode = bw_s; // [RULE7]
        n.addr_lo = address_select_strap_s; // [RULE3]
        n.strap_done = 1'h1;
      end
    end

    if (start_w) begin
      n.state = cbuf_pkg::FSM_ADDR;
      n.bitcnt = 4'h0;
      n.stage = 2'h0;
      n.sda_oe_b = 1'h1;
    end else if (stop_w) begin
      n.state = cbuf_pkg::FSM_IDLE; // [RULE2]
      n.sda_oe_b = 1'h1;
    end else begin
      case (r.state)
        cbuf_pkg::FSM_ADDR, cbuf_pkg::FSM_RX: begin
          if (rise_w) begin
            n.sh = {r.sh[6:0], sda_s};
            n.bitcnt = r.bitcnt + 4'h1;
          end else if (fall_w && r.bitcnt == 4'h8) begin
            n.bitcnt = 4'h0;
            n.state = cbuf_pkg::FSM_ACK;
            n.sda_oe_b = 1'h0; // [RULE4]
            if (r.state == cbuf_pkg::FSM_ADDR) begin
              n.is_read = r.sh[0];
              if (!addr_hit_w) begin
                // Other targets' traffic is left alone until the next start
                n.state = cbuf_pkg::FSM_IGN; // [RULE1]
                n.sda_oe_b = 1'h1;
              end
            end else begin
              case (r.stage)
                2'h0: begin
                  n.idx = r.sh;
                  n.stage = 2'h1;
                end
                2'h1: begin
                  n.stage = 2'h2;
                end
                default: begin
                  n.idx = r.idx + 8'h01; // [RULE22]
                  case (r.idx)
                    cbuf_pkg::REG_OUT_EN: begin
                      n.en1 = r.sh[cbuf_pkg::BIT_OUT1]; // [RULE6]
                      n.en0 = r.sh[cbuf_pkg::BIT_OUT0]; // [RULE6]
                    end
                    cbuf_pkg::REG_PLL_AMP: begin
                      n.pll_ovr = r.sh[cbuf_pkg::BIT_PLL_OVR]; // [RULE8]
                      n.pll_sw = r.sh[cbuf_pkg::BIT_PLL_SW +: 2];
                      n.amp = r.sh[cbuf_pkg::BIT_AMP +: 2]; // [RULE9]
                    end
                    cbuf_pkg::REG_SLEW: begin
                      n.slew1 = r.sh[cbuf_pkg::BIT_OUT1]; // [RULE10]
                      n.slew0 = r.sh[cbuf_pkg::BIT_OUT0]; // [RULE10]
                    end
                    cbuf_pkg::REG_FREQ: begin
                      n.fsel_en = r.sh[cbuf_pkg::BIT_FSEL_EN]; // [RULE11]
                      n.fcode = r.sh[cbuf_pkg::BIT_FCODE +: 2]; // [RULE12]
                      n.fb_fast = r.sh[cbuf_pkg::BIT_FB_SLEW]; // [RULE13]
                    end
                    cbuf_pkg::REG_RD_CNT: begin
                      n.bcount = r.sh[4:0]; // [RULE16]
                    end
                    default: begin
                      // Read-only and reserved bytes drop the data
                      n.idx = r.idx + 8'h01; // [RULE22]
                    end
                  endcase
                end
              endcase
            end
          end
        end
        cbuf_pkg::FSM_ACK: begin
          if (fall_w) begin
            n.sda_oe_b = 1'h1;
            n.state = cbuf_pkg::FSM_RX;
            if (r.is_read) begin
              // A read opens with the byte count, then data from the index
              n.sh = {cbuf_pkg::CNT_RSV[1:0], r.bcount, 1'h0}; // [RULE5]
              n.sda_oe_b = cbuf_pkg::CNT_RSV[2];
              n.bitcnt = 4'h1;
              n.state = cbuf_pkg::FSM_TX;
            end
          end
        end
        cbuf_pkg::FSM_TX: begin
          if (fall_w) begin
            if (r.bitcnt == 4'h8) begin
              n.sda_oe_b = 1'h1;
              n.state = cbuf_pkg::FSM_HACK;
            end else begin
              n.sda_oe_b = r.sh[7];
              n.sh = {r.sh[6:0], 1'h0};
              n.bitcnt = r.bitcnt + 4'h1;
            end
          end
        end
        cbuf_pkg::FSM_HACK: begin
          if (rise_w) begin
            n.acked = ~sda_s;
            if (sda_s) begin
              n.state = cbuf_pkg::FSM_IGN; // [RULE5]
            end
          end else if (fall_w && r.acked) begin
            n.acked = 1'h0;
            n.sh = {tb[6:0], 1'h0};
            n.sda_oe_b = tb[7];
            n.idx = r.idx + 8'h01; // [RULE22]
            n.bitcnt = 4'h1;
            n.state = cbuf_pkg::FSM_TX;
          end
        end
        cbuf_pkg::FSM_IDLE, cbuf_pkg::FSM_IGN: begin
          n.sda_oe_b = 1'h1;
        end
        default: begin
          n.state = cbuf_pkg::FSM_IDLE;
          n.sda_oe_b = 1'h1;
        end
      endcase
    end

    // Start-up hold-off, restarted by every power-down
    if (!pd_s) begin
      n.stab_cnt = 18'h0;
      n.stab_done = 1'h0;
    end else if (!r.stab_done) begin
      if (r.stab_cnt == 18'(STAB_CYCLES - 1)) begin
        n.stab_done = 1'h1; // [RULE17]
      end else begin
        n.stab_cnt = r.stab_cnt + 18'h1;
      end
    end

    // Output pairs; a stopped pair parks low/low, never mid-swing
    n.o0p = run0_w ? ~r.o0p : 1'h0; // [RULE21]
    n.o0n = run0_w ? r.o0p : 1'h0;
    n.o1p = run1_w ? ~r.o1p : 1'h0; // [RULE21]
    n.o1n = run1_w ? r.o1p : 1'h0;

    n.pll_mode = r.pll_ovr ? r.pll_sw : r.bw_mode; // [RULE8] [RULE19]
    n.freq = r.fsel_en ? r.fcode : cbuf_pkg::FREQ_100; // [RULE11] [RULE20]
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      r <= cbuf_pkg::ST_RST;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign sda_o = r.sda_lvl;
  assign sda_oe_b_o = r.sda_oe_b;
  assign out0_pair_p_o = r.o0p;
  assign out0_pair_n_o = r.o0n;
  assign out1_pair_p_o = r.o1p;
  assign out1_pair_n_o = r.o1n;
  assign pll_mode_o = r.pll_mode;
  assign amplitude_o = r.amp;
  assign out0_slew_fast_o = r.slew0;
  assign out1_slew_fast_o = r.slew1;
  assign freq_code_o = r.freq;
  assign feedback_slew_fast_o = r.fb_fast;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence s_quiet;
    !start_w && !stop_w;
  endsequence

  sequence s_rx_byte;
    (r.state == cbuf_pkg::FSM_RX) && fall_w && (r.bitcnt == 4'h8);
  endsequence

  sequence s_addr_miss;
    (r.state == cbuf_pkg::FSM_ADDR) && fall_w && (r.bitcnt == 4'h8) &&
    !addr_hit_w;
  endsequence

  sequence s_wr_data;
    (r.state == cbuf_pkg::FSM_RX) && fall_w && (r.bitcnt == 4'h8) &&
    (r.stage == 2'h2);
  endsequence

  a_ack_rx_byte: assert property ((s_rx_byte and s_quiet) |=> // [RULE4]
    (!sda_oe_b_o && r.state == cbuf_pkg::FSM_ACK))
    else $error("received byte not acknowledged");

  a_addr_reject: assert property ((s_addr_miss and s_quiet) |=> // [RULE3]
    (sda_oe_b_o && r.state == cbuf_pkg::FSM_IGN) ##1 sda_oe_b_o)
    else $error("foreign address was acknowledged");

  a_host_nack: assert property (((r.state == cbuf_pkg::FSM_HACK) && // [RULE5]
    rise_w && sda_s && !start_w && !stop_w) |=>
    (r.state == cbuf_pkg::FSM_IGN && sda_oe_b_o))
    else $error("read not ended by host nack");

  a_stop_release: assert property (stop_w && !start_w |=> // [RULE2]
    (r.state == cbuf_pkg::FSM_IDLE && sda_oe_b_o))
    else $error("stop did not release the bus");

  a_pd_forces_low: assert property (!pd_s |=> // [RULE18]
    (!out0_pair_p_o && !out0_pair_n_o && !out1_pair_p_o && !out1_pair_n_o))
    else $error("outputs running in power-down");

  a_en_bit_low: assert property ((!r.en0 |=> !out0_pair_p_o) and // [RULE6]
    (!r.en1 |=> !out1_pair_p_o))
    else $error("disabled output still toggling");

  a_stab_hold: assert property (!r.stab_done |=> // [RULE17]
    (!out0_pair_p_o && !out1_pair_p_o))
    else $error("output before start-up hold-off expired");

  a_out_toggles: assert property (run0_w |=> // [RULE21]
    (out0_pair_p_o != $past(out0_pair_p_o) &&
     out0_pair_n_o == !out0_pair_p_o))
    else $error("enabled output not toggling");

  a_pll_source: assert property (1'h1 |=> // [RULE8]
    (pll_mode_o == ($past(r.pll_ovr) ? $past(r.pll_sw) : $past(r.bw_mode))))
    else $error("wrong pll mode source");

  a_freq_default: assert property (!r.fsel_en |=> // [RULE11]
    (freq_code_o == cbuf_pkg::FREQ_100))
    else $error("frequency code used while disabled");

  a_wr_idx_step: assert property ((s_wr_data and s_quiet) |=> // [RULE22]
    (r.idx == $past(r.idx) + 8'h01))
    else $error("register index did not advance");

  a_strap_frozen: assert property (r.strap_done |=> // [RULE7]
    ($stable(r.bw_mode) && $stable(r.addr_lo)))
    else $error("latched strap changed");

endmodule : cbuf_smbus_cfg
`default_nettype wire

// [cbuf_host_model.sv]
// Host model for the configuration bank's two-wire management bus.
// Assumes a pull-up outside: the wire is low while either party pulls it.
`timescale 1ns/10ps
`default_nettype none
module cbuf_host_model (
  input wire logic lclk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  // Both lines released at rest; SCL stands high outside frames
  initial begin
    scl_o = 1'h1;
    sda_o = 1'h1;
  end
  ////////////////////////////////////////////////////////////////////////////
  // One bit per three link clocks; SDA moves only while SCL is low
  task automatic bit_io(input logic b, output logic r);
    @(posedge lclk_i) sda_o = b;
    @(posedge lclk_i) scl_o = 1'h1;
    @(posedge lclk_i) r = sda_i;
    scl_o = 1'h0;
  endtask : bit_io
  // Also serves as repeated start from a low SCL
  task automatic start;
    @(posedge lclk_i) sda_o = 1'h1;
    @(posedge lclk_i) scl_o = 1'h1;
    @(posedge lclk_i) sda_o = 1'h0;
    @(posedge lclk_i) scl_o = 1'h0;
  endtask : start
  task automatic stop;
    @(posedge lclk_i) sda_o = 1'h0;
    @(posedge lclk_i) scl_o = 1'h1;
    @(posedge lclk_i) sda_o = 1'h1;
  endtask : stop
  // Byte out MSB first, then the ninth bit released for the target
  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'h1, r);
    ack = !r;
  endtask : put
  // Byte in; a low ninth bit asks for more, a high one ends the read
  task automatic get(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'h1, d[i]);
    bit_io(last, r);
  endtask : get
endmodule : cbuf_host_model
`default_nettype wire

// [cbuf_smbus_cfg_bench.sv]
// Self-checking bench of the configuration bank, driven by the host model.
// Assumes a short start-up count so output checks stay brief.
`timescale 1ns/10ps
`default_nettype none
module cbuf_smbus_cfg_bench;
  localparam int STAB = 20;
  localparam logic [2:0] STRAP = 3'h5;
  localparam logic [6:0] ADR = {cbuf_pkg::ADDR_HI, STRAP};
  localparam logic [7:0] RST_TBL [0:7] = '{8'hFF, 8'hC6, 8'hFF, 8'hC7,
    8'hFF, {cbuf_pkg::REV_ID, cbuf_pkg::VENDOR_ID},
    {cbuf_pkg::ZERO_DELAY_BUFFER_TYPE, cbuf_pkg::PART_ID}, 8'h08};
  localparam logic [1:0] MODES [0:3] = '{cbuf_pkg::PLL_LOW_BW,
    cbuf_pkg::PLL_BYPASS, cbuf_pkg::PLL_HIGH_BW, cbuf_pkg::PLL_LOW_BW};
  logic mclk, lclk, rst_b, scl, h_sda, sda_oe_b, sda_d, ok;
  logic oe0_n, oe1_n, pd_n, p0, n0, p1, n1, s0, s1, fbs;
  logic [1:0] bw, pll, amp, frq;
  logic [7:0] rb [0:7];
  logic [7:0] wb [0:7];
  wire logic sda_w;
  int n_fail, checks;
  // Open-drain wire with pull-up
  assign sda_w = h_sda & (sda_oe_b | sda_d);
  initial begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end
  // Link clock at one twelfth of the system clock, rising 1 ns after a system clock rising edge
  initial begin
    lclk = 1'h0;
    #7;
    forever #24 lclk = ~lclk;
  end
  cbuf_smbus_cfg #(.STAB_CYCLES(STAB)) dut (.mclk_i(mclk), .rst_b_i(rst_b),
    .scl_i(scl), .sda_i(sda_w), .out0_enable_pin_n_i(oe0_n),
    .out1_enable_pin_n_i(oe1_n), .power_down_pin_n_i(pd_n),
    .bandwidth_strap_pin_i(bw), .address_select_strap_i(STRAP),
    .sda_o(sda_d), .sda_oe_b_o(sda_oe_b), .out0_pair_p_o(p0),
    .out0_pair_n_o(n0), .out1_pair_p_o(p1), .out1_pair_n_o(n1),
    .pll_mode_o(pll), .amplitude_o(amp), .out0_slew_fast_o(s0),
    .out1_slew_fast_o(s1), .freq_code_o(frq), .feedback_slew_fast_o(fbs));
  cbuf_host_model host (.lclk_i(lclk), .sda_i(sda_w), .scl_o(scl),
    .sda_o(h_sda));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict
  // Sticky acknowledge over a whole transfer
  task automatic send(input logic [7:0] d);
    logic a;
    host.put(d, a);
    ok = ok & a;
  endtask : send
  task automatic wr(input logic [7:0] idx, input int n);
    ok = 1'h1;
    host.start();
    send({ADR, 1'h0});
    send(idx);
    send(8'(n));
    for (int i = 0; i < n; i++) send(wb[i]);
    host.stop();
    check(ok, 1'h1);
  endtask : wr
  task automatic wr1(input logic [7:0] idx, input logic [7:0] d);
    wb[0] = d;
    wr(idx, 1);
  endtask : wr1
  task automatic rd(input logic [7:0] idx, input int n, input logic [7:0] c);
    logic [7:0] got;
    ok = 1'h1;
    host.start();
    send({ADR, 1'h0});
    send(idx);
    host.start();
    send({ADR, 1'h1});
    check(ok, 1'h1);
    host.get(1'h0, got);
    check(got, c);
    for (int i = 0; i < n; i++) host.get(i == n - 1, rb[i]);
    host.stop();
  endtask : rd
  // Bit per pair: running means toggling with complementary legs
  task automatic run_chk(input logic [1:0] exp);
    logic [3:0] a;
    logic [3:0] b;
    repeat (6) @(negedge mclk);
    a = {p1, n1, p0, n0};
    @(negedge mclk);
    b = {p1, n1, p0, n0};
    check({(a[3] ^ b[3]) & (a[3] ^ a[2]), (a[1] ^ b[1]) & (a[1] ^ a[0])},
      exp);
    check(a & ~{exp[1], exp[1], exp[0], exp[0]}, 4'h0);
  endtask : run_chk
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #300000;
    n_fail++;
    give_verdict();
  end
  initial begin
    rst_b = 1'h0;
    oe0_n = 1'h0;
    oe1_n = 1'h0;
    pd_n = 1'h1;
    bw = cbuf_pkg::PLL_HIGH_BW;
    n_fail = 0;
    checks = 0;
    ok = 1'h1;
    repeat (3) @(negedge mclk);
    rst_b = 1'h1;
    run_chk(2'h0);
    repeat (STAB) @(negedge mclk);
    run_chk(2'h3);
    check({pll, amp, frq}, {2'h3, 2'h2, 2'h0});
    check({s1, s0, fbs}, 3'h7);
    rd(8'h00, 8, 8'h08);
    for (int i = 0; i < 8; i++) check(rb[i], RST_TBL[i]);
    // Wrong low address bits must go unanswered
    ok = 1'h1;
    host.start();
    send({cbuf_pkg::ADDR_HI, ~STRAP, 1'h0});
    host.stop();
    check(ok, 1'h0);
    // Early stop after the index byte, then normal traffic resumes
    host.start();
    send({ADR, 1'h0});
    send(8'h01);
    host.stop();
    for (int i = 0; i < 4; i++) begin
      wr1(8'h01, {3'h1, MODES[i], 1'h0, 2'(i)});
      check({pll, amp}, {MODES[i], 2'(i)});
      rd(8'h01, 1, 8'h08);
      check(rb[0], {3'h7, MODES[i], 1'h1, 2'(i)});
    end
    wr1(8'h01, 8'h0B);
    check(pll, 2'h3);
    for (int i = 0; i < 3; i++) begin
      wr1(8'h03, {3'h1, 2'(i), 3'h0});
      check({frq, fbs}, {2'(i), 1'h0});
    end
    wr1(8'h03, 8'h11);
    check({frq, fbs}, 3'h1);
    wr1(8'h02, 8'h08);
    check({s1, s0}, 2'h1);
    // Enables: pin, register bit and power-down each stop a pair
    @(negedge mclk);
    oe0_n = 1'h1;
    run_chk(2'h2);
    oe0_n = 1'h0;
    wr1(8'h00, 8'hF7);
    run_chk(2'h2);
    wr1(8'h00, 8'hDF);
    run_chk(2'h1);
    pd_n = 1'h0;
    run_chk(2'h0);
    pd_n = 1'h1;
    run_chk(2'h0);
    repeat (STAB) @(negedge mclk);
    run_chk(2'h1);
    // Block write across read-only bytes into the count register
    wb[0] = 8'hAA;
    wb[1] = 8'h55;
    wb[2] = 8'h00;
    wb[3] = 8'hE3;
    wr(8'h04, 4);
    rd(8'h04, 4, 8'h03);
    for (int i = 0; i < 4; i++) check(rb[i], (i == 3) ? 8'h03 :
      RST_TBL[i + 4]);
    give_verdict();
  end
endmodule : cbuf_smbus_cfg_bench
`default_nettype wire
